// ===== shared/lpm_map.svh
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH

// Register byte offsets
`define LPM_CTRL_ADDR 12'h000
`define LPM_STAT_ADDR 12'h004
`define LPM_WAKE_ADDR 12'h008
`define LPM_ADDR_W 12

// Control register fields
`define LPM_SRC_LSB 0
`define LPM_SRC_MSB 1
`define LPM_OSCEN_LSB 2
`define LPM_OSCEN_MSB 4
`define LPM_GEAR_LSB 5
`define LPM_GEAR_MSB 6
`define LPM_PCLK_OFF_BIT 7
`define LPM_CTRL_W 8
`define LPM_CTRL_RST 8'h1D

// Status register fields
`define LPM_ST_STATE_LSB 0
`define LPM_ST_STATE_MSB 1
`define LPM_ST_STABLE_LSB 2
`define LPM_ST_STABLE_MSB 4
`define LPM_ST_RTC_KEPT_BIT 5

// Wake cause bits
`define LPM_WK_PORT 0
`define LPM_WK_RTC 1
`define LPM_WK_LSPER 2
`define LPM_WK_PCLK 3
`define LPM_WK_OTHER 4
`define LPM_WK_W 5

// Oscillator indices
`define LPM_OSC_N 3
`define LPM_OSC_LS 0
`define LPM_OSC_HSA 1
`define LPM_OSC_HSB 2

`define LPM_GEAR_W 2
`define LPM_GEAR_CNT_W 3

`endif

// ===== shared/lpm_pkg.sv
package lpm_pkg;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE  = 2'b11,
      ST_HALT  = 2'b10
   } lpm_state_t;

   typedef logic [1:0] osc_sel_t;
endpackage : lpm_pkg

// ===== core/cpu_gear_divider.sv
`timescale 1ns/1ps
`include "lpm_map.svh"

// One-in-N tick for the CPU clock gate, N = 1, 2, 4 or 8
module cpu_gear_divider (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic [`LPM_GEAR_W-1:0] gear,
   // Result
   output logic tick
);
   logic [`LPM_GEAR_CNT_W-1:0] cnt_q;
   logic [`LPM_GEAR_CNT_W-1:0] mask;
   logic [`LPM_GEAR_CNT_W-1:0] one;

   assign one = `LPM_GEAR_CNT_W'(1);
   assign mask = (one << gear) - one;
   assign tick = run && ((cnt_q & mask) == '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + one;
      end
   end
endmodule : cpu_gear_divider

// ===== core/low_power_mode_clock_gating.sv
// Summary of operation
// - Sleep with RTC stopped halts low-speed and both high-speed oscillators.
// - That deep sleep wakes only on the port path.
// - Sleep with RTC running stops only the high-speed oscillators.
// - That sleep wakes on port or RTC interrupt, nothing else.
// - Halt stops only the CPU clock; peripherals keep running.
// - Halt ends on port or running-peripheral interrupt; CPU clock returns.
// - CPU clock is system clock divided by 1, 2, 4 or 8.
// - Software gate stops the peripheral clock.
// - RTC, timers, display, UART etc. run without the peripheral clock.
// - Software picks system clock source; unused oscillators may be off.
// - Port interrupt or debugger forced break forms the port wake path.
// - RTC interrupt is its own wake-up source.
// - Clock timer or watchdog interrupt wakes the CPU from halt while the low-speed oscillator is enabled.
// - Peripheral-clock peripherals wake the CPU while that clock runs.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lpm_map.svh"

module low_power_mode_clock_gating
   import lpm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`LPM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU core requests
   input wire logic sleep_req,
   input wire logic halt_req,
   // Wake sources
   input wire logic port_irq,
   input wire logic on_chip_debugger_break,
   input wire logic rtc_irq,
   input wire logic rtc_running,
   input wire logic clock_timer_irq,
   input wire logic watchdog_irq,
   input wire logic pclk_periph_irq,
   input wire logic free_periph_irq,
   // Oscillator interface
   input wire logic [`LPM_OSC_N-1:0] osc_stable,
   output logic low_speed_osc_en,
   output logic high_speed_osc_a_en,
   output logic high_speed_osc_b_en,
   output logic [1:0] sys_clk_sel,
   // Clock gates
   output logic cpu_core_clock_en,
   output logic peripheral_clock_en,
   // Mode status
   output logic cpu_sleeping,
   output logic cpu_halted,
   output logic cpu_wake
);
   // Oscillator stable inputs arrive from other clocks
   logic [`LPM_OSC_N-1:0] stab_s1_q;
   logic [`LPM_OSC_N-1:0] stab_s2_q;
   logic [`LPM_OSC_N-1:0] stab_s3_q;
   logic [`LPM_OSC_N-1:0] stable_q;

   genvar gi;
   generate
      for (gi = 0; gi < `LPM_OSC_N; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stab_s1_q[gi] <= 1'b0;
               stab_s2_q[gi] <= 1'b0;
               stab_s3_q[gi] <= 1'b0;
               stable_q[gi] <= 1'b0;
            end else begin
               stab_s1_q[gi] <= osc_stable[gi];
               stab_s2_q[gi] <= stab_s1_q[gi];
               stab_s3_q[gi] <= stab_s2_q[gi];
               if (stab_s2_q[gi] == stab_s3_q[gi]) begin
                  stable_q[gi] <= stab_s3_q[gi];
               end
            end
         end
      end
   endgenerate

   // Registers
   logic [`LPM_CTRL_W-1:0] ctrl_q;
   logic [`LPM_CTRL_W-1:0] ctrl_d;
   logic [`LPM_WK_W-1:0] wake_q;
   logic [`LPM_WK_W-1:0] wake_d;
   lpm_state_t state_q;
   lpm_state_t state_d;
   logic rtc_kept_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;

   // Control fields
   wire osc_sel_t src = ctrl_q[`LPM_SRC_MSB:`LPM_SRC_LSB];
   wire [`LPM_OSC_N-1:0] osc_req = ctrl_q[`LPM_OSCEN_MSB:`LPM_OSCEN_LSB];
   wire [`LPM_GEAR_W-1:0] gear = ctrl_q[`LPM_GEAR_MSB:`LPM_GEAR_LSB];
   wire pclk_off = ctrl_q[`LPM_PCLK_OFF_BIT];

   // APB decode
   wire access = psel && penable;
   wire done = access && pready_q;
   wire wr_fire = done && pwrite;
   wire hit_ctrl = paddr == `LPM_CTRL_ADDR;
   wire hit_stat = paddr == `LPM_STAT_ADDR;
   wire hit_wake = paddr == `LPM_WAKE_ADDR;
   wire mapped = hit_ctrl || hit_stat || hit_wake;
   wire wr_ctrl = wr_fire && hit_ctrl;
   wire wr_wake = wr_fire && hit_wake;

   // Source oscillator can be switched off only in sleep
   wire [`LPM_OSC_N-1:0] src_onehot = `LPM_OSC_N'(1) << src;
   wire [`LPM_OSC_N-1:0] osc_run_en = osc_req | src_onehot;
   wire src_stable = |(stable_q & src_onehot);

   // Oscillator enables per mode
   wire ls_keep = osc_run_en[`LPM_OSC_LS] && rtc_kept_q;
   wire in_sleep = state_q == ST_SLEEP;
   wire osc_ls_d = in_sleep ? ls_keep : osc_run_en[`LPM_OSC_LS];
   wire osc_hsa_d = !in_sleep && osc_run_en[`LPM_OSC_HSA];
   wire osc_hsb_d = !in_sleep && osc_run_en[`LPM_OSC_HSB];

   // Peripheral clock: gated by software and stopped in sleep
   wire pclk_run = !pclk_off && !in_sleep && state_q != ST_WAKE;

   // Wake sources
   wire port_wake = port_irq || on_chip_debugger_break;
   wire ls_per_irq = clock_timer_irq || watchdog_irq;
   wire ls_alive = osc_run_en[`LPM_OSC_LS];
   wire pclk_alive = !pclk_off;
   // Sleep wake: port only, plus RTC when it was kept running
   wire sleep_wake = port_wake || (rtc_kept_q && rtc_irq);
   // Halt wake: port or any peripheral still clocked
   wire halt_wake = port_wake || rtc_irq
      || (ls_alive && ls_per_irq)
      || (pclk_alive && pclk_periph_irq)
      || free_periph_irq;

   wire [`LPM_WK_W-1:0] sleep_cause = {
      1'b0, 1'b0, 1'b0, rtc_kept_q && rtc_irq, port_wake};
   wire [`LPM_WK_W-1:0] halt_cause = {
      free_periph_irq,
      pclk_alive && pclk_periph_irq,
      ls_alive && ls_per_irq,
      rtc_irq,
      port_wake};

   // Mode sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: begin
            if (sleep_req) begin
               state_d = ST_SLEEP;
            end else if (halt_req) begin
               state_d = ST_HALT;
            end
         end
         ST_SLEEP: begin
            if (sleep_wake) begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (src_stable) begin
               state_d = ST_RUN;
            end
         end
         ST_HALT: begin
            if (halt_wake) begin
               state_d = ST_RUN;
            end
         end
      endcase
   end

   wire sleep_enter = state_q == ST_RUN && sleep_req;
   wire sleep_exit = in_sleep && sleep_wake;
   wire halt_exit = state_q == ST_HALT && halt_wake;

   // Wake cause flags: set wins over a write-one clear
   wire [`LPM_WK_W-1:0] cause_set =
      (sleep_exit ? sleep_cause : '0) | (halt_exit ? halt_cause : '0);
   wire [`LPM_WK_W-1:0] cause_clr =
      wr_wake ? pwdata[`LPM_WK_W-1:0] : '0;

   always_comb begin
      wake_d = (wake_q & ~cause_clr) | cause_set;
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = pwdata[`LPM_CTRL_W-1:0];
      end
   end

   // CPU clock gear
   logic gear_tick;
   wire cpu_run = state_d == ST_RUN;

   cpu_gear_divider u_gear (
      .pclk(pclk),
      .presetn(presetn),
      .run(cpu_run),
      .gear(gear),
      .tick(gear_tick)
   );

   // Read mux
   wire [31:0] stat_word = {
      26'h0,
      rtc_kept_q,
      stable_q,
      state_q};
   wire [31:0] rd_word =
      hit_ctrl ? {24'h0, ctrl_q} :
      hit_stat ? stat_word :
      hit_wake ? {27'h0, wake_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `LPM_CTRL_RST;
         wake_q <= '0;
         state_q <= ST_RUN;
         rtc_kept_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         wake_q <= wake_d;
         state_q <= state_d;
         if (sleep_enter) begin
            rtc_kept_q <= rtc_running;
         end
      end
   end

   // APB answer: one wait state per access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && !mapped;
         if (access && !pready_q && !pwrite) begin
            prdata_q <= rd_word;
         end
      end
   end

   // Registered outputs
   logic ls_en_q;
   logic hsa_en_q;
   logic hsb_en_q;
   logic [1:0] sel_q;
   logic cpu_en_q;
   logic pclk_en_q;
   logic sleeping_q;
   logic halted_q;
   logic wake_pulse_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_en_q <= 1'b1;
         hsa_en_q <= 1'b1;
         hsb_en_q <= 1'b0;
         sel_q <= 2'h0;
         cpu_en_q <= 1'b0;
         pclk_en_q <= 1'b0;
         sleeping_q <= 1'b0;
         halted_q <= 1'b0;
         wake_pulse_q <= 1'b0;
      end else begin
         ls_en_q <= osc_ls_d;
         hsa_en_q <= osc_hsa_d;
         hsb_en_q <= osc_hsb_d;
         sel_q <= src;
         cpu_en_q <= gear_tick;
         pclk_en_q <= pclk_run;
         sleeping_q <= state_d == ST_SLEEP;
         halted_q <= state_d == ST_HALT;
         wake_pulse_q <= sleep_exit || halt_exit;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign low_speed_osc_en = ls_en_q;
   assign high_speed_osc_a_en = hsa_en_q;
   assign high_speed_osc_b_en = hsb_en_q;
   assign sys_clk_sel = sel_q;
   assign cpu_core_clock_en = cpu_en_q;
   assign peripheral_clock_en = pclk_en_q;
   assign cpu_sleeping = sleeping_q;
   assign cpu_halted = halted_q;
   assign cpu_wake = wake_pulse_q;
endmodule : low_power_mode_clock_gating

// ===== testbench/lpm_monitor.sv
`timescale 1ns/1ps
module lpm_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requests and wake inputs
   input wire logic sleep_req,
   input wire logic halt_req,
   input wire logic port_irq,
   input wire logic on_chip_debugger_break,
   input wire logic rtc_irq,
   input wire logic rtc_running,
   input wire logic clock_timer_irq,
   input wire logic watchdog_irq,
   input wire logic pclk_periph_irq,
   input wire logic free_periph_irq,
   // Clock outputs and mode
   input wire logic low_speed_osc_en,
   input wire logic high_speed_osc_a_en,
   input wire logic high_speed_osc_b_en,
   input wire logic cpu_core_clock_en,
   input wire logic peripheral_clock_en,
   input wire logic cpu_sleeping,
   input wire logic cpu_halted,
   input wire logic cpu_wake
);
   logic rtc_q;
   logic slp_q;
   logic kept_q;
   wire port_path = port_irq | on_chip_debugger_break;
   wire other_irq = clock_timer_irq | watchdog_irq | rtc_irq | free_periph_irq;
   // RTC state captured on the cycle sleep was entered
   wire kept = (cpu_sleeping && !slp_q) ? rtc_q : kept_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_q <= 1'b0;
         slp_q <= 1'b0;
         kept_q <= 1'b0;
      end else begin
         rtc_q <= rtc_running;
         slp_q <= cpu_sleeping;
         kept_q <= kept;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence sleep_held;
      cpu_sleeping ##1 cpu_sleeping;
   endsequence
   sequence halt_held;
      cpu_halted ##1 cpu_halted;
   endsequence
   chk_sleep_taken: assert property (
      sleep_req && cpu_core_clock_en |=> cpu_sleeping && !cpu_core_clock_en)
      else $error("sleep request not taken");
   chk_halt_taken: assert property (
      halt_req && !sleep_req && cpu_core_clock_en |=> cpu_halted && !cpu_core_clock_en)
      else $error("halt request not taken");
   chk_hs_stopped: assert property (
      sleep_held |-> !high_speed_osc_a_en && !high_speed_osc_b_en)
      else $error("high speed oscillator on in sleep");
   chk_ls_follows_rtc: assert property (
      sleep_held |-> low_speed_osc_en == kept)
      else $error("low speed oscillator wrong in sleep");
   chk_port_wakes: assert property (
      cpu_sleeping && port_path |=> cpu_wake && !cpu_sleeping)
      else $error("port path did not end sleep");
   chk_sleep_filter: assert property (
      cpu_sleeping && !port_path && !(rtc_irq && kept) |=> cpu_sleeping)
      else $error("sleep ended without allowed source");
   chk_rtc_wakes: assert property (
      cpu_sleeping && kept && rtc_irq |=> cpu_wake)
      else $error("rtc interrupt did not end sleep");
   chk_halt_wakes: assert property (
      cpu_halted && (port_path || rtc_irq || free_periph_irq) |=> !cpu_halted ##0 cpu_wake)
      else $error("halt not ended by interrupt");
   chk_gated_hold: assert property (
      cpu_halted && !peripheral_clock_en && !port_path && !other_irq |=> cpu_halted)
      else $error("halt ended by gated peripheral");
   chk_halt_osc_kept: assert property (
      halt_held |-> $stable({low_speed_osc_en, high_speed_osc_a_en, high_speed_osc_b_en}))
      else $error("oscillator changed in halt");
endmodule : lpm_monitor

bind low_power_mode_clock_gating lpm_monitor lpm_monitor_i (.pclk, .presetn,
   .sleep_req, .halt_req, .port_irq, .on_chip_debugger_break, .rtc_irq, .rtc_running,
   .clock_timer_irq, .watchdog_irq, .pclk_periph_irq, .free_periph_irq, .low_speed_osc_en,
   .high_speed_osc_a_en, .high_speed_osc_b_en, .cpu_core_clock_en, .peripheral_clock_en,
   .cpu_sleeping, .cpu_halted, .cpu_wake);

// ===== testbench/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
   // Clock
   input wire logic pclk,
   // Oscillator enables
   input wire logic [2:0] osc_en,
   // Requests and oscillator status
   output logic sleep_req,
   output logic halt_req,
   output logic [2:0] osc_stable
);
   logic [2:0] warm1_q = 3'h0;
   logic [2:0] warm2_q = 3'h0;
   initial begin
      sleep_req = 1'b0;
      halt_req = 1'b0;
   end
   // Oscillator settles some cycles after enable, drops on the next clock edge when stopped
   always @(posedge pclk) begin
      warm1_q <= osc_en;
      warm2_q <= warm1_q & osc_en;
      osc_stable <= warm2_q & osc_en;
   end
   // Issue one sleep or halt instruction
   task automatic run_instr(input logic slp);
      @(posedge pclk);
      sleep_req <= slp;
      halt_req <= !slp;
      @(posedge pclk);
      sleep_req <= 1'b0;
      halt_req <= 1'b0;
   endtask : run_instr
endmodule : cpu_core_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rtc_running = 0, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rdata, cnt;
   logic [6:0] irq = 7'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sleep_req, halt_req, low_speed_osc_en, high_speed_osc_a_en;
   logic high_speed_osc_b_en, cpu_core_clock_en, peripheral_clock_en;
   logic cpu_sleeping, cpu_halted, cpu_wake;
   logic [1:0] sys_clk_sel;
   logic [2:0] osc_stable;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   int src_ix[4] = '{5, 3, 4, 2};
   wire [2:0] oscs = {high_speed_osc_b_en, high_speed_osc_a_en, low_speed_osc_en};
   always #2.5 pclk = ~pclk;
   low_power_mode_clock_gating low_power_mode_clock_gating_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_req, .halt_req,
      .port_irq(irq[0]), .on_chip_debugger_break(irq[1]), .rtc_irq(irq[2]), .rtc_running,
      .clock_timer_irq(irq[3]), .watchdog_irq(irq[4]), .pclk_periph_irq(irq[5]),
      .free_periph_irq(irq[6]), .osc_stable, .low_speed_osc_en, .high_speed_osc_a_en,
      .high_speed_osc_b_en, .sys_clk_sel, .cpu_core_clock_en, .peripheral_clock_en,
      .cpu_sleeping, .cpu_halted, .cpu_wake);
   cpu_core_model cpu_core_model_i (.pclk, .osc_en(oscs), .sleep_req, .halt_req, .osc_stable);
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only pready or the bench timeout ends this wait
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rdata);
   endtask : rd_chk
   task automatic try_wake(input int i, input logic e);
      int t;
      @(posedge pclk);
      irq <= 7'(1 << i);
      @(posedge pclk);
      irq <= 7'h0;
      #1 chk("wake", 32'(e), 32'(cpu_wake));
      if (e) begin
         for (t = 0; t < 40 && cpu_core_clock_en !== 1'b1; t++) @(posedge pclk);
         chk("cpu clock back", 32'h1, 32'(cpu_core_clock_en));
      end
   endtask : try_wake
   task automatic enter(input logic slp);
      cpu_core_model_i.run_instr(slp);
      repeat (2) @(posedge pclk);
      #1;
   endtask : enter
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("ctrl", 12'h000, 32'h1D);
      // Let the third oscillator's stable flag pass the synchroniser
      repeat (8) @(posedge pclk);
      rd_chk("status", 12'h004, 32'h3C);
      rd_chk("unmapped", 12'h00C, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      for (int g = 0; g < 4; g++) begin
         apb(1'b1, 12'h000, 32'h1D | (g << 5));
         repeat (2) @(posedge pclk);
         cnt = 0;
         repeat (16) begin
            @(posedge pclk);
            cnt += 32'(cpu_core_clock_en);
         end
         chk("gear ticks", 32'(16 >> g), cnt);
      end
      apb(1'b1, 12'h000, 32'h00);
      repeat (3) @(posedge pclk);
      chk("ls source", 32'h04, 32'({oscs, sys_clk_sel}));
      apb(1'b1, 12'h000, 32'h02);
      repeat (3) @(posedge pclk);
      chk("source", 32'h12, 32'({oscs, sys_clk_sel}));
      apb(1'b1, 12'h000, 32'h9D);
      repeat (2) @(posedge pclk);
      chk("pclk gate", 32'h0, 32'(peripheral_clock_en));
      enter(1'b0);
      try_wake(5, 1'b0);
      try_wake(6, 1'b1);
      apb(1'b1, 12'h000, 32'h1D);
      for (int k = 0; k < 4; k++) begin
         enter(1'b0);
         try_wake(src_ix[k], 1'b1);
      end
      @(posedge pclk) rtc_running <= 1'b0;
      enter(1'b1);
      chk("deep osc", 32'h0, 32'(oscs));
      try_wake(2, 1'b0);
      try_wake(3, 1'b0);
      try_wake(1, 1'b1);
      chk("osc back", 32'h7, 32'(oscs));
      @(posedge pclk) rtc_running <= 1'b1;
      enter(1'b1);
      chk("rtc osc", 32'h1, 32'(oscs));
      try_wake(4, 1'b0);
      try_wake(6, 1'b0);
      try_wake(2, 1'b1);
      apb(1'b1, 12'h008, 32'h1F);
      enter(1'b0);
      try_wake(0, 1'b1);
      rd_chk("cause", 12'h008, 32'h01);
      close_out();
   end
endmodule : tb
